// [logic/cdb_cost.sv]
// Cost calculator: core and bus clocks of one instruction.
// Assumes the caller samples the result on accept.
`include "cdb_regs.svh"
`default_nettype none

module cdb_cost (
    // Request
    input  wire cdb_pkg::cdb_req_t   req,
    input  wire cdb_pkg::cdb_shape_t shape,
    input  wire logic                wbuf_full,
    // Result
    output var  cdb_pkg::cdb_cost_t  cost
);
    import cdb_pkg::*;

    logic [3:0] r;
    logic [3:0] b;
    logic [3:0] w;

    function automatic logic [3:0] clamp4(input logic [3:0] v,
                                          input logic [3:0] lo);
        clamp4 = (v < lo) ? lo : v;
    endfunction

    // One first read plus three burst transfers
    function automatic logic [9:0] line_time(input logic [3:0] rr,
                                             input logic [3:0] bb);
        line_time = {6'h00, rr} + 10'(3 * bb);
    endfunction

    // shape clamp
    // Slower than 2-1-2 is fine, faster is not supported
    always_comb
    begin
        r = clamp4(shape.r, `CDB_MIN_R);
        b = clamp4(shape.b, `CDB_MIN_B);
        w = clamp4(shape.w, `CDB_MIN_W);
    end

    always_comb
    begin
        cost.core = {2'h0, req.base_clks} + {2'h0, req.data_clks};
        if (req.misaligned)
            cost.core = cost.core + `CDB_MISALIGN_CLKS;
        if (req.base_dep && !req.push_pop)
            cost.core = cost.core + `CDB_ONE_CLK;
        if (req.use_index)
            cost.core = cost.core + `CDB_ONE_CLK;
        if (req.disp_imm)
            cost.core = cost.core + `CDB_ONE_CLK;
        if (req.tlb_lvl != 2'h0)
            cost.core = cost.core + `CDB_ONE_CLK;

        cost.bus = `CDB_COUNT_RST;
        if (req.miss)
            cost.bus = {2'h0, req.miss_bus} + {6'h00, r} - 10'h002;
        if (req.jump_miss)
        begin
            cost.bus = cost.bus + {6'h00, r};
            if (req.jump_dword)
                cost.bus = cost.bus + 10'(3 * b);
            if (req.jump_line)
                cost.bus = cost.bus + line_time(r, b);
        end
        unique case (req.tlb_lvl)
            2'h0: cost.bus = cost.bus;
            2'h1: cost.bus = cost.bus + `CDB_TLB_NONE_CLKS;
            2'h2: cost.bus = cost.bus + `CDB_TLB_ONE_CLKS;
            2'h3: cost.bus = cost.bus + `CDB_TLB_BOTH_CLKS;
        endcase
        if (req.multi_unal && req.miss)
            cost.bus = cost.bus + line_time(r, b);
        if (req.is_write && wbuf_full)
            cost.bus = cost.bus + {6'h00, w};
    end

endmodule

`default_nettype wire

// [logic/cdb_pkg.sv]
// Types shared by the clock-doubled core timing block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cdb_pkg;

    // One instruction to be timed
    typedef struct packed {
        logic [7:0] base_clks;
        logic [7:0] miss_bus;
        logic [7:0] data_clks;
        logic       miss;
        logic       misaligned;
        logic       base_dep;
        logic       push_pop;
        logic       use_index;
        logic       disp_imm;
        logic [1:0] tlb_lvl;
        logic       jump_miss;
        logic       jump_dword;
        logic       jump_line;
        logic       multi_unal;
        logic       is_write;
        logic       fill_line;
    } cdb_req_t;

    // Bus shape in bus clocks
    typedef struct packed {
        logic [3:0] r;
        logic [3:0] b;
        logic [3:0] w;
    } cdb_shape_t;

    // Core clocks and bus clocks of one instruction
    typedef struct packed {
        logic [9:0] core;
        logic [9:0] bus;
    } cdb_cost_t;

    typedef enum logic [2:0] {
        CDB_IDLE  = 3'b000,
        CDB_FILLW = 3'b001,
        CDB_CORE  = 3'b010,
        CDB_BUS   = 3'b011,
        CDB_DONE  = 3'b100
    } cdb_state_t;

endpackage

`default_nettype wire

// [logic/cdb_regs.svh]
// Constants for the clock-doubled core timing block.
// Assumes inclusion by the design modules only; cdb_pkg.sv does not include it.
`ifndef CDB_REGS_SVH
`define CDB_REGS_SVH

// Core clocks per bus clock
`define CDB_BUS_RATIO      2
// Fastest bus shape r-b-w
`define CDB_MIN_R          4'h2
`define CDB_MIN_B          4'h1
`define CDB_MIN_W          4'h2
// Core clock penalties
`define CDB_MISALIGN_CLKS  10'h003
`define CDB_ONE_CLK        10'h001
// Page walk bus clocks: no, one, both entries updated
`define CDB_TLB_NONE_CLKS  10'h00D
`define CDB_TLB_ONE_CLKS   10'h015
`define CDB_TLB_BOTH_CLKS  10'h01C
// Reset values
`define CDB_GDR_RST        16'h0000
`define CDB_UP_N_RST       1'b0
`define CDB_COUNT_RST      10'h000

`endif

// [logic/cdb_top.sv]
// Timing core of a clock-doubled socket upgrade processor.
// Assumes sys_clk is the core clock; the bus runs at half of it.
`include "cdb_regs.svh"
`default_nettype none

module cdb_top #(
    // Arbitrary identifier; low nibble is the stepping
    parameter logic [15:0] COMP_ID = 16'hB792
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    // Instruction request
    input  wire logic                req_valid,
    input  wire cdb_pkg::cdb_req_t   req,
    input  wire cdb_pkg::cdb_shape_t shape,
    output logic                     req_ready,
    // System bus status
    input  wire logic                bus_avail,
    input  wire logic                fill_busy,
    input  wire logic                wbuf_full,
    input  wire logic                inval_cycle,
    output logic                     bus_clk,
    output logic                     bus_cyc,
    // Completion
    output logic                     done,
    output logic [10:0]              elapsed_clks,
    output logic [10:0]              est_clks,
    // Identification and pins
    output logic [15:0]              general_data_register,
    output logic                     id_valid,
    output logic                     upgrade_present_n,
    output logic                     tdo,
    output logic                     tdo_oe
);
    import cdb_pkg::*;

    cdb_state_t  state_r;
    cdb_state_t  state_nxt;
    cdb_cost_t   cost_w;
    logic [9:0]  core_left_r;
    logic [9:0]  bus_left_r;
    logic        bus_en;
    logic        accept;
    logic        bus_step;
    logic        core_last;
    logic        bus_last;

    function automatic logic [10:0] dbl(input logic [9:0] v);
        dbl = 11'(v * `CDB_BUS_RATIO);
    endfunction

    cdb_cost u_cost (
        .req       (req),
        .shape     (shape),
        .wbuf_full (wbuf_full),
        .cost      (cost_w)
    );

    // ******************************
    // Clocks and identification
    // ******************************

    // bus at half rate
    // Bus enable is the low phase, so each bus edge is a core edge
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            bus_clk <= 1'b0;
        else
            bus_clk <= ~bus_clk;
    end
    assign bus_en = ~bus_clk;

    // load component id
    // Loaded on the first edge after release, not under reset
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            general_data_register <= `CDB_GDR_RST;
            id_valid              <= 1'b0;
        end
        else if (!id_valid)
        begin
            general_data_register <= COMP_ID;
            id_valid              <= 1'b1;
        end
    end

    // test port inert
    // Low from reset on so glue sees the upgrade during reset too
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            upgrade_present_n <= `CDB_UP_N_RST;
            tdo               <= 1'b0;
            tdo_oe            <= 1'b0;
        end
        else
        begin
            upgrade_present_n <= `CDB_UP_N_RST;
            tdo               <= 1'b0;
            tdo_oe            <= 1'b0;
        end
    end

    // ******************************
    // Sequencer
    // ******************************

    assign accept    = req_valid && req_ready;
    assign bus_step  = bus_en && bus_avail;
    assign core_last = core_left_r <= `CDB_ONE_CLK;
    assign bus_last  = bus_step && !inval_cycle
                       && (bus_left_r == `CDB_ONE_CLK);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            CDB_IDLE:
                if (accept)
                    state_nxt = (req.fill_line && fill_busy)
                                ? CDB_FILLW : CDB_CORE;
            CDB_FILLW:
                if (!fill_busy)
                    state_nxt = CDB_CORE;
            CDB_CORE:
                if (core_last)
                    state_nxt = (bus_left_r != `CDB_COUNT_RST)
                                ? CDB_BUS : CDB_DONE;
            CDB_BUS:
                if (bus_last)
                    state_nxt = CDB_DONE;
            CDB_DONE:
                state_nxt = CDB_IDLE;
            default:
                state_nxt = CDB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= CDB_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            core_left_r <= `CDB_COUNT_RST;
        else if (accept)
            core_left_r <= cost_w.core;
        else if (state_r == CDB_CORE && !core_last)
            core_left_r <= core_left_r - `CDB_ONE_CLK;
    end

    // invalidate adds clock
    // Counting on bus enable makes each bus clock two core clocks
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            bus_left_r <= `CDB_COUNT_RST;
        else if (accept)
            bus_left_r <= cost_w.bus;
        else if (state_r == CDB_BUS)
        begin
            if (inval_cycle && !bus_step)
                bus_left_r <= bus_left_r + `CDB_ONE_CLK;
            else if (bus_step && !inval_cycle)
                bus_left_r <= bus_left_r - `CDB_ONE_CLK;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_cyc   <= 1'b0;
            req_ready <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            bus_cyc   <= state_nxt == CDB_BUS;
            req_ready <= state_nxt == CDB_IDLE && id_valid;
            done      <= state_nxt == CDB_DONE;
        end
    end

    // Measured core clocks and the stall-free estimate
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            elapsed_clks <= 11'h000;
            est_clks     <= 11'h000;
        end
        else if (accept)
        begin
            elapsed_clks <= 11'h001;
            est_clks     <= {1'b0, cost_w.core} + dbl(cost_w.bus);
        end
        else if (state_r != CDB_IDLE && state_r != CDB_DONE)
            elapsed_clks <= elapsed_clks + 11'h001;
    end

    // ******************************
    // Checks
    // ******************************

    property p_up_low;
        @(posedge sys_clk) disable iff (!resetn)
        id_valid |-> !upgrade_present_n;
    endproperty
    a_up_low: assert property (p_up_low)
        else $error("upgrade present not low");

    property p_no_scan;
        @(posedge sys_clk) disable iff (!resetn)
        !tdo_oe && !tdo;
    endproperty
    a_no_scan: assert property (p_no_scan)
        else $error("test output driven");

    property p_id_load;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(id_valid) |-> general_data_register == COMP_ID
            ##1 $stable(general_data_register);
    endproperty
    a_id_load: assert property (p_id_load)
        else $error("component id not loaded");

    property p_phase;
        @(posedge sys_clk) disable iff (!resetn)
        bus_clk |=> !bus_clk ##1 bus_clk;
    endproperty
    a_phase: assert property (p_phase)
        else $error("bus clock phase broken");

    property p_bus_rate;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == CDB_BUS && !bus_en && !inval_cycle
            |=> $stable(bus_left_r);
    endproperty
    a_bus_rate: assert property (p_bus_rate)
        else $error("bus count moved off bus enable");

    property p_fill_wait;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == CDB_FILLW && fill_busy |=> state_r == CDB_FILLW
            && !done;
    endproperty
    a_fill_wait: assert property (p_fill_wait)
        else $error("left fill wait early");

    property p_miss_bus;
        @(posedge sys_clk) disable iff (!resetn)
        accept && req.miss && req.miss_bus != 8'h00
            |=> bus_left_r != `CDB_COUNT_RST;
    endproperty
    a_miss_bus: assert property (p_miss_bus)
        else $error("miss without bus cycle");

    property p_misalign;
        @(posedge sys_clk) disable iff (!resetn)
        accept && req.misaligned && !req.base_dep && !req.use_index
            && !req.disp_imm && req.tlb_lvl == 2'h0
            |-> cost_w.core == {2'h0, req.base_clks}
                + {2'h0, req.data_clks} + 10'h003;
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("misaligned penalty wrong");

    property p_wbuf;
        @(posedge sys_clk) disable iff (!resetn)
        accept && req.is_write && !req.miss && !req.jump_miss
            && req.tlb_lvl == 2'h0 && shape.w >= 4'h2
            |-> cost_w.bus == (wbuf_full ? {6'h00, shape.w} : 10'h000);
    endproperty
    a_wbuf: assert property (p_wbuf)
        else $error("write buffer penalty wrong");

    property p_inval;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == CDB_BUS && inval_cycle && !bus_step
            |=> bus_left_r == $past(bus_left_r) + 10'h001;
    endproperty
    a_inval: assert property (p_inval)
        else $error("invalidate not charged");

endmodule

`default_nettype wire

// [testbench/cdb_sys_model.sv]
// System-side partner: bus availability, line fills, invalidates.
// Assumes the bench sets the modes; drives only at falling edges.
`default_nettype none

module cdb_sys_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Modes set by the bench
    input  wire logic       stall_en,
    input  wire logic       inval_en,
    input  wire logic       fill_go,
    input  wire logic [7:0] fill_len,
    // Device side
    input  wire logic       upgrade_present_n,
    output logic            bus_avail,
    output logic            fill_busy,
    output logic            inval_cycle,
    output logic            upgrade_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    int fill_left;

    always @(negedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_avail <= 1'b1;
            fill_busy <= 1'b0;
            inval_cycle <= 1'b0;
            upgrade_seen <= 1'b0;
            fill_left = 0;
        end
        else
        begin
            bus_avail <= stall_en ? ($urandom_range(0, 3) != 0) : 1'b1;
            inval_cycle <= inval_en && ($urandom_range(0, 7) == 0);
            if (fill_go)
                fill_left = fill_len;
            else if (fill_left > 0)
                fill_left--;
            fill_busy <= fill_go || (fill_left > 0);
            upgrade_seen <= !upgrade_present_n;
        end
    end
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the clock-doubled core timing block.
// Assumes cdb_pkg, cdb_top and cdb_sys_model are compiled first.
`default_nettype none

module testbench;
    import cdb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary identifier value, not any real part's code
    localparam logic [15:0] ID_VAL = 16'hC6E1;

    logic        sys_clk, resetn, req_valid, wbuf_full, req_ready;
    logic        bus_avail, fill_busy, inval_cycle, bus_clk, bus_cyc;
    logic        done, id_valid, upgrade_present_n, tdo, tdo_oe;
    logic        stall_en, inval_en, fill_go, upgrade_seen, bclk_q, live;
    logic [7:0]  fill_len;
    logic [10:0] elapsed_clks, est_clks;
    logic [15:0] general_data_register;
    cdb_req_t    req, q;
    cdb_shape_t  shape;
    int          miscompares, n_compared, i;

    cdb_top #(.COMP_ID(ID_VAL)) i_cdb_top (
        .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
        .req(req), .shape(shape), .req_ready(req_ready),
        .bus_avail(bus_avail), .fill_busy(fill_busy),
        .wbuf_full(wbuf_full), .inval_cycle(inval_cycle),
        .bus_clk(bus_clk), .bus_cyc(bus_cyc), .done(done),
        .elapsed_clks(elapsed_clks), .est_clks(est_clks),
        .general_data_register(general_data_register),
        .id_valid(id_valid), .upgrade_present_n(upgrade_present_n),
        .tdo(tdo), .tdo_oe(tdo_oe));

    cdb_sys_model i_cdb_sys_model (
        .sys_clk(sys_clk), .resetn(resetn), .stall_en(stall_en),
        .inval_en(inval_en), .fill_go(fill_go), .fill_len(fill_len),
        .upgrade_present_n(upgrade_present_n), .bus_avail(bus_avail),
        .fill_busy(fill_busy), .inval_cycle(inval_cycle),
        .upgrade_seen(upgrade_seen));

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic cmp_rng(input string nm, input int lo, input int hi,
                           input int g);
        n_compared++;
        if (g < lo || g > hi)
        begin
            miscompares++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic timeout();
        miscompares++;
        $display("BAD wait expected completion seen timeout");
        results();
    endtask

    function automatic cdb_shape_t sh(input int r, input int b, input int w);
        sh = '{r: r[3:0], b: b[3:0], w: w[3:0]};
    endfunction

    // Core and bus clocks, with the shape clamped up to 2-1-2
    function automatic void cost(input cdb_req_t x, input cdb_shape_t s,
                                 input logic wb, output int c, output int b);
        int r, bb, w;
        r = (s.r < 4'h2) ? 2 : s.r;
        bb = (s.b < 4'h1) ? 1 : s.b;
        w = (s.w < 4'h2) ? 2 : s.w;
        c = x.base_clks + x.data_clks + 3 * x.misaligned + x.use_index
            + (x.base_dep && !x.push_pop) + x.disp_imm + (x.tlb_lvl != 0);
        b = x.miss ? x.miss_bus + r - 2 : 0;
        b += x.tlb_lvl == 1 ? 13 : x.tlb_lvl == 2 ? 21 : 0;
        b += x.tlb_lvl == 3 ? 28 : 0;
        b += x.jump_miss ? r + 3 * bb * x.jump_dword : 0;
        b += (x.jump_miss && x.jump_line) ? r + 3 * bb : 0;
        b += (x.miss && x.multi_unal) ? r + 3 * bb : 0;
        b += (x.is_write && wb) ? w : 0;
    endfunction

    // ****************************************
    // Stimulus tasks
    // ****************************************
    task automatic do_reset(input int cyc);
        @(negedge sys_clk);
        resetn = 1'b0;
        #1;
        cmp_bit("req_ready in reset", 1'b0, req_ready);
        cmp_bit("up_n in reset", 1'b0, upgrade_present_n);
        cmp("id in reset", 16'h0000, general_data_register);
        repeat (cyc) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        @(posedge sys_clk);
        #1;
        cmp("id after reset", ID_VAL, general_data_register);
        cmp_bit("id_valid", 1'b1, id_valid);
    endtask

    task automatic run_op(input cdb_req_t x, input cdb_shape_t s,
                          input logic wb, input int fl);
        int c, b, c1, n, lo, hi;
        logic bs;
        cost(x, s, wb, c, b);
        c1 = (c < 1) ? 1 : c;
        n = 0;
        bs = 1'b0;
        @(negedge sys_clk);
        while (req_ready !== 1'b1)
        begin
            if (++n > 300) timeout();
            @(negedge sys_clk);
        end
        req = x;
        shape = s;
        wbuf_full = wb;
        fill_len = fl[7:0];
        fill_go = (fl > 0);
        // Fill start held over two model edges, so its race with us is moot
        @(negedge sys_clk);
        req_valid = 1'b1;
        @(posedge sys_clk);
        fill_go <= 1'b0;
        @(negedge sys_clk);
        req_valid = 1'b0;
        // Counts edges from accept up to the one that samples done high
        n = 1;
        while (done !== 1'b1)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            bs |= (bus_cyc === 1'b1);
            if (n > 1500) timeout();
        end
        lo = c1 + 1;
        hi = lo;
        if (b > 0)
        begin
            lo = c1 + 2 * b - 1;
            hi = (stall_en || inval_en) ? 2047 : c1 + 2 * b + 2;
        end
        if (fl > 0)
        begin
            lo = fl + c1 - 1;
            hi = fl + c1 + 2;
        end
        cmp("est_clks", 16'(c + 2 * b), {5'h00, est_clks});
        cmp("elapsed_clks", 16'(n), {5'h00, elapsed_clks});
        cmp_rng("op duration", lo, hi, n);
        cmp_bit("bus_cyc on miss", b > 0, bs);
        @(posedge sys_clk);
        #1;
        cmp_bit("done pulse", 1'b0, done);
    endtask

    // ****************************************
    // Clock, pin monitor and main sequence
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        #1;
        if (resetn && live)
            cmp_bit("bus_clk toggle", ~bclk_q, bus_clk);
        cmp_bit("upgrade_present_n", 1'b0, upgrade_present_n);
        cmp_bit("tdo", 1'b0, tdo);
        cmp_bit("tdo_oe", 1'b0, tdo_oe);
        bclk_q = bus_clk;
        live = resetn;
    end

    initial
    begin
        {resetn, req_valid, wbuf_full, stall_en, inval_en, fill_go} = '0;
        {req, q, shape, fill_len, live, bclk_q} = '0;
        miscompares = 0;
        n_compared = 0;
        void'($urandom(94));
        do_reset(5);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp_bit("upgrade seen", 1'b1, upgrade_seen);
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        q.base_clks = 8'h05;
        q.misaligned = 1'b1;
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        q = '0;
        q.base_dep = 1'b1;
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        q.push_pop = 1'b1;
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        q = '0;
        q.use_index = 1'b1;
        q.disp_imm = 1'b1;
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        for (i = 1; i < 4; i++)
        begin
            q = '0;
            q.tlb_lvl = i[1:0];
            run_op(q, sh(3, 1, 2), 1'b0, 0);
        end
        q = '0;
        q.is_write = 1'b1;
        run_op(q, sh(2, 1, 3), 1'b1, 0);
        run_op(q, sh(2, 1, 3), 1'b0, 0);
        q = '0;
        q.miss = 1'b1;
        q.miss_bus = 8'h04;
        q.data_clks = 8'h03;
        run_op(q, sh(5, 2, 2), 1'b0, 0);
        run_op(q, sh(0, 0, 0), 1'b0, 0);
        q.multi_unal = 1'b1;
        run_op(q, sh(3, 2, 2), 1'b0, 0);
        q = '0;
        q.jump_miss = 1'b1;
        run_op(q, sh(3, 2, 2), 1'b0, 0);
        q.jump_dword = 1'b1;
        run_op(q, sh(3, 2, 2), 1'b0, 0);
        q.jump_line = 1'b1;
        run_op(q, sh(3, 2, 2), 1'b0, 0);
        q = '0;
        q.fill_line = 1'b1;
        q.base_clks = 8'h02;
        run_op(q, sh(2, 1, 2), 1'b0, 6);
        for (i = 0; i < 40; i++)
        begin
            q = '0;
            q.base_clks = 8'($urandom_range(0, 15));
            q.miss = 1'($urandom_range(0, 1));
            q.miss_bus = q.miss ? 8'($urandom_range(0, 15)) : 8'h00;
            q.data_clks = q.miss ? 8'($urandom_range(0, 7)) : 8'h00;
            q.multi_unal = q.miss & 1'($urandom_range(0, 1));
            q.misaligned = 1'($urandom_range(0, 1));
            q.tlb_lvl = 2'($urandom_range(0, 3));
            q.jump_miss = 1'($urandom_range(0, 1));
            q.jump_dword = q.jump_miss & 1'($urandom_range(0, 1));
            q.is_write = 1'($urandom_range(0, 1));
            stall_en = 1'($urandom_range(0, 1));
            inval_en = 1'($urandom_range(0, 1));
            run_op(q, sh($urandom_range(0, 6), $urandom_range(0, 3),
                   $urandom_range(0, 4)), 1'($urandom_range(0, 1)), 0);
        end
        stall_en = 1'b0;
        inval_en = 1'b0;
        q = '0;
        q.base_clks = 8'h14;
        @(negedge sys_clk);
        req = q;
        req_valid = 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        repeat (2) @(posedge sys_clk);
        do_reset(2);
        run_op(q, sh(2, 1, 2), 1'b0, 0);
        results();
    end
endmodule

`default_nettype wire
